/* File: core/bbx_pkg.sv */
// How it works
// - Bit-clear writes zero into bit 0..7 of data register 0..127, leaves the others, touches no flag.
// - Bit-set writes one into bit 0..7 of data register 0..127, leaves the others, touches no flag.
// - Literal branch jumps to PC plus one plus a signed 9-bit offset (-256..255) in two cycles, no flags.
// - Register branch jumps to PC plus one plus the unsigned working register in two cycles, no flags.
// - Skip-if-clear runs the next instruction when the bit is one, else turns it into a no-op (two cycles).
// - Skip-if-set runs the next instruction when the bit is zero, else turns it into a no-op (two cycles).
// - Call pushes PC plus one, loads the 11-bit literal into PC[10:0] and latch bits 6:3 into PC[14:11].
// - Call takes exactly two instruction cycles and changes no flag.
package bbx_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PC_W    = 15;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int RADDR_W = 7;
  localparam int BIDX_W  = 3;
  localparam int LATCH_W = 7;
  localparam int CNT_W   = 32;

  // ----------------------------------------
  // Opcode fields and encodings
  // ----------------------------------------
  localparam int BITOP_HI  = 13;
  localparam int BITOP_LO  = 12;
  localparam int BITSEL_HI = 11;
  localparam int BITSEL_LO = 10;
  localparam int BIDX_HI   = 9;
  localparam int BIDX_LO   = 7;
  localparam int RADDR_HI  = 6;
  localparam int BRA_HI    = 13;
  localparam int BRA_LO    = 9;
  localparam int BRA_K_HI  = 8;
  localparam int CALL_HI   = 13;
  localparam int CALL_LO   = 11;
  localparam int CALL_K_HI = 10;
  localparam int LATCH_HI  = 6;
  localparam int LATCH_LO  = 3;

  localparam logic [1:0]         BITOP_GRP   = 2'h1;
  localparam logic [1:0]         SEL_CLR     = 2'h0;
  localparam logic [1:0]         SEL_SET     = 2'h1;
  localparam logic [1:0]         SEL_TSTCLR  = 2'h2;
  localparam logic [1:0]         SEL_TSTSET  = 2'h3;
  localparam logic [4:0]         BRA_GRP     = 5'h19;
  localparam logic [2:0]         CALL_GRP    = 3'h4;
  localparam logic [INSTR_W-1:0] BRW_CODE    = 14'h000B;

  // ----------------------------------------
  // Reset values and steps
  // ----------------------------------------
  localparam logic [PC_W-1:0]  PC_RST   = 15'h0000;
  localparam logic [PC_W-1:0]  PC_ONE   = 15'h0001;
  localparam logic [PC_W-1:0]  PC_TWO   = 15'h0002;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    BBX_ST_EXEC  = 2'b01,
    BBX_ST_FLUSH = 2'b10
  } bbx_state_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic               we;
    logic [RADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } bbx_rf_wr_t;

  typedef struct packed {
    logic            push;
    logic [PC_W-1:0] addr;
  } bbx_push_t;

  typedef struct packed {
    bbx_state_t       st;
    logic [PC_W-1:0]  pc;
    bbx_rf_wr_t       wr;
    bbx_push_t        stk;
    logic             retire;
    logic             foreign;
    logic             nop;
    logic [CNT_W-1:0] cycles;
  } bbx_regs_t;

endpackage : bbx_pkg

/* File: core/bbx_bit_unit.sv */
`timescale 1ns/1ns
module bbx_bit_unit #(
  parameter int WIDTH = 8,
  parameter int IDX_W = 3
) (
  // Operand
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic [IDX_W-1:0] i_idx,
  input  wire logic             i_val,
  // Results
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_bit
);

  always_comb begin
    o_data        = i_data;
    o_data[i_idx] = i_val;
    o_bit         = i_data[i_idx];
  end

endmodule : bbx_bit_unit

/* File: core/bbx_exec.sv */
`timescale 1ns/1ns
module bbx_exec
  import bbx_pkg::*;
(
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_nrst,
  // Instruction cycle strobe from the core divider
  input  wire logic               i_cyc_en,
  // Program memory
  output logic      [PC_W-1:0]    o_pc,
  input  wire logic [INSTR_W-1:0] i_instr,
  // Data register file
  output logic      [RADDR_W-1:0] o_rf_raddr,
  input  wire logic [DATA_W-1:0]  i_rf_rdata,
  output logic                    o_rf_we,
  output logic      [RADDR_W-1:0] o_rf_waddr,
  output logic      [DATA_W-1:0]  o_rf_wdata,
  // Core registers
  input  wire logic [DATA_W-1:0]  i_wreg,
  input  wire logic [LATCH_W-1:0] i_upper_pc_latch,
  // Return stack
  output logic                    o_push,
  output logic      [PC_W-1:0]    o_push_addr,
  // Status
  output logic                    o_retire,
  output logic                    o_foreign,
  output logic                    o_nop,
  output logic      [CNT_W-1:0]   o_cycles
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic               is_bitop;
  logic               is_bra;
  logic               is_brw;
  logic               is_call;
  logic [1:0]         bit_sel;
  logic [BIDX_W-1:0]  bit_idx;
  logic [RADDR_W-1:0] reg_addr;
  logic [8:0]         bra_k;
  logic [10:0]        call_k;

  // Opcode groups are disjoint, so the order of the if chain below is free
  always_comb begin
    is_bitop = i_instr[BITOP_HI:BITOP_LO] == BITOP_GRP;
    is_bra   = i_instr[BRA_HI:BRA_LO] == BRA_GRP;
    is_brw   = i_instr == BRW_CODE;
    is_call  = i_instr[CALL_HI:CALL_LO] == CALL_GRP;
    bit_sel  = i_instr[BITSEL_HI:BITSEL_LO];
    bit_idx  = i_instr[BIDX_HI:BIDX_LO];
    reg_addr = i_instr[RADDR_HI:0];
    bra_k    = i_instr[BRA_K_HI:0];
    call_k   = i_instr[CALL_K_HI:0];
  end

  assign o_rf_raddr = reg_addr;

  // ----------------------------------------
  // Operand with write forwarding
  // ----------------------------------------
  bbx_regs_t         s_q;
  bbx_regs_t         s_d;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] bit_wdata;
  logic              bit_tested;

  // Posted write lands one clock late, so a back-to-back read of the
  // same register must see the pending value rather than the stale one.
  always_comb begin
    if (s_q.wr.we && (s_q.wr.addr == reg_addr)) begin
      operand = s_q.wr.data;
    end else begin
      operand = i_rf_rdata;
    end
  end

  bbx_bit_unit #(
    .WIDTH (DATA_W),
    .IDX_W (BIDX_W)
  ) u_bit (
    .i_data (operand),
    .i_idx  (bit_idx),
    .i_val  (bit_sel == SEL_SET),
    .o_data (bit_wdata),
    .o_bit  (bit_tested)
  );

  // ----------------------------------------
  // Target arithmetic
  // ----------------------------------------
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] bra_tgt;
  logic [PC_W-1:0] brw_tgt;
  logic [PC_W-1:0] call_tgt;

  // Sums are cut to PC width on purpose: targets wrap, never saturate

  always_comb begin
    pc_inc   = PC_W'(s_q.pc + PC_ONE);
    bra_tgt  = PC_W'(pc_inc + {{(PC_W-9){bra_k[8]}}, bra_k});
    brw_tgt  = PC_W'(pc_inc + {{(PC_W-DATA_W){1'b0}}, i_wreg});
    call_tgt = {i_upper_pc_latch[LATCH_HI:LATCH_LO], call_k};
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // None of these opcodes touch status; flags live outside this block
  // and no flag write port exists here at all.
  always_comb begin
    s_d         = s_q;
    s_d.wr.we   = 1'b0;
    s_d.stk.push = 1'b0;
    s_d.retire  = 1'b0;
    s_d.foreign = 1'b0;
    s_d.nop     = 1'b0;
    if (i_cyc_en) begin
      s_d.cycles = s_q.cycles + CNT_ONE;
      case (s_q.st)
        BBX_ST_EXEC: begin
          s_d.retire = 1'b1;
          s_d.pc     = pc_inc;
          if (is_bitop) begin
            case (bit_sel)
              SEL_CLR, SEL_SET: begin
                s_d.wr.we   = 1'b1;
                s_d.wr.addr = reg_addr;
                s_d.wr.data = bit_wdata;
              end
              SEL_TSTCLR: begin
                if (!bit_tested) begin
                  s_d.pc = PC_W'(s_q.pc + PC_TWO);
                  s_d.st = BBX_ST_FLUSH;
                end
              end
              SEL_TSTSET: begin
                if (bit_tested) begin
                  s_d.pc = PC_W'(s_q.pc + PC_TWO);
                  s_d.st = BBX_ST_FLUSH;
                end
              end
              default: begin
                s_d.foreign = 1'b1;
              end
            endcase
          end else if (is_bra) begin
            s_d.pc = bra_tgt;
            s_d.st = BBX_ST_FLUSH;
          end else if (is_brw) begin
            s_d.pc = brw_tgt;
            s_d.st = BBX_ST_FLUSH;
          end else if (is_call) begin
            s_d.stk.push = 1'b1;
            s_d.stk.addr = pc_inc;
            s_d.pc       = call_tgt;
            s_d.st       = BBX_ST_FLUSH;
          end else begin
            // Executed by the rest of the core as a single cycle op
            s_d.foreign = 1'b1;
          end
        end
        BBX_ST_FLUSH: begin
          // Discarded fetch runs as a no-op; PC already holds the target
          s_d.nop = 1'b1;
          s_d.st  = BBX_ST_EXEC;
        end
        default: begin
          s_d.st = BBX_ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      // Pulses clear too, so no stale write or push leaves reset
      s_q.st      <= BBX_ST_EXEC;
      s_q.pc      <= PC_RST;
      s_q.wr      <= '0;
      s_q.stk     <= '0;
      s_q.retire  <= 1'b0;
      s_q.foreign <= 1'b0;
      s_q.nop     <= 1'b0;
      s_q.cycles  <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_pc        = s_q.pc;
  assign o_rf_we     = s_q.wr.we;
  assign o_rf_waddr  = s_q.wr.addr;
  assign o_rf_wdata  = s_q.wr.data;
  assign o_push      = s_q.stk.push;
  assign o_push_addr = s_q.stk.addr;
  assign o_retire    = s_q.retire;
  assign o_foreign   = s_q.foreign;
  assign o_nop       = s_q.nop;
  assign o_cycles    = s_q.cycles;

endmodule : bbx_exec

/* File: test/bbx_exec_sva.sv */
`timescale 1ns/1ns
module bbx_exec_sva
  import bbx_pkg::*;
(
  input wire logic i_ref_clk, i_nrst, i_cyc_en, o_rf_we, o_push, o_retire, o_foreign, o_nop,
  input wire logic [PC_W-1:0]    o_pc, o_push_addr,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic [RADDR_W-1:0] o_rf_raddr, o_rf_waddr,
  input wire logic [DATA_W-1:0]  i_rf_rdata, o_rf_wdata, i_wreg,
  input wire logic [LATCH_W-1:0] i_upper_pc_latch,
  input wire logic [CNT_W-1:0]   o_cycles
);
  logic [DATA_W-1:0]  rd, wx, w_q, wx_q;
  logic [PC_W-1:0]    pc_q;
  logic [INSTR_W-1:0] in_q;
  logic [LATCH_W-1:0] lat_q;
  logic               bt, tk, cl, br, rw, two, ex, fl_q, tk_q;
  // Forward a pending write, else a back-to-back bit op reads stale data
  always_comb begin
    rd = (o_rf_we && o_rf_waddr == i_instr[6:0]) ? o_rf_wdata : i_rf_rdata;
    wx = i_instr[10] ? rd | (8'h01 << i_instr[9:7]) : rd & ~(8'h01 << i_instr[9:7]);
    bt = i_instr[13:12] == BITOP_GRP;
    tk = bt && i_instr[11] && rd[i_instr[9:7]] == i_instr[10];
    cl = i_instr[13:11] == CALL_GRP;
    br = i_instr[13:9] == BRA_GRP;
    rw = i_instr == BRW_CODE;
    two = tk || cl || br || rw;
    ex = i_nrst && i_cyc_en && !fl_q;
  end
  always_ff @(posedge i_ref_clk) begin
    pc_q <= o_pc;
    in_q <= i_instr;
    lat_q <= i_upper_pc_latch;
    w_q <= i_wreg;
    wx_q <= wx;
    tk_q <= tk;
    fl_q <= i_nrst && (i_cyc_en ? ex && two : fl_q);
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_call_target: assert property (
    ex && cl |=> o_pc == {lat_q[6:3], in_q[10:0]}) else $error("call target wrong");
  a_call_push: assert property (
    ex && cl |=> o_push && o_push_addr == pc_q + PC_ONE) else $error("call push wrong");
  a_lit_branch: assert property (
    ex && br |=> o_pc == pc_q + PC_ONE + {{6{in_q[8]}}, in_q[8:0]}) else $error("bad branch");
  a_reg_branch: assert property (
    ex && rw |=> o_pc == pc_q + PC_ONE + {7'h00, w_q}) else $error("bad register branch");
  a_skip_step: assert property (
    ex && bt && i_instr[11] |=> o_pc == pc_q + (tk_q ? PC_TWO : PC_ONE)) else $error("bad skip");
  a_bit_write: assert property (
    ex && bt && !i_instr[11] |=> o_rf_we && o_rf_waddr == in_q[6:0] && o_rf_wdata == wx_q)
    else $error("bad bit write");
  a_two_cycle: assert property (
    ex && two ##1 i_cyc_en |=> o_nop && $stable(o_pc)) else $error("no discard cycle");
  a_cycle_count: assert property (
    i_cyc_en |=> o_cycles == $past(o_cycles) + CNT_ONE) else $error("cycle count wrong");
  a_retire_pulse: assert property (
    ex |=> o_retire) else $error("no retire pulse");
  a_foreign_step: assert property (
    ex && !bt && !cl && !br && !rw |=> o_foreign && o_pc == pc_q + PC_ONE)
    else $error("bad foreign step");
  a_stall_quiet: assert property (
    !i_cyc_en |=> !o_retire && !o_nop && !o_push && !o_rf_we) else $error("pulse while stalled");
  a_read_addr: assert property (
    o_rf_raddr == i_instr[6:0]) else $error("bad read address");
endmodule : bbx_exec_sva

bind bbx_exec bbx_exec_sva u_sva (
  .i_ref_clk        (i_ref_clk),
  .i_nrst           (i_nrst),
  .i_cyc_en         (i_cyc_en),
  .o_rf_we          (o_rf_we),
  .o_push           (o_push),
  .o_retire         (o_retire),
  .o_foreign        (o_foreign),
  .o_nop            (o_nop),
  .o_pc             (o_pc),
  .o_push_addr      (o_push_addr),
  .i_instr          (i_instr),
  .o_rf_raddr       (o_rf_raddr),
  .o_rf_waddr       (o_rf_waddr),
  .i_rf_rdata       (i_rf_rdata),
  .o_rf_wdata       (o_rf_wdata),
  .i_wreg           (i_wreg),
  .i_upper_pc_latch (i_upper_pc_latch),
  .o_cycles         (o_cycles)
);

/* File: test/bbx_mem_model.sv */
`timescale 1ns/1ns
module bbx_mem_model
  import bbx_pkg::*;
(
  input  wire logic               i_ref_clk, i_we, i_push,
  input  wire logic [PC_W-1:0]    i_pc, i_push_addr,
  input  wire logic [RADDR_W-1:0] i_raddr, i_waddr,
  input  wire logic [DATA_W-1:0]  i_wdata,
  output logic      [INSTR_W-1:0] o_instr,
  output logic      [DATA_W-1:0]  o_rdata
);
  // Zero is an instruction outside this block
  logic [INSTR_W-1:0] imem [32768] = '{default: 14'h0000};
  logic [DATA_W-1:0]  rf [128] = '{default: 8'h00};
  logic [PC_W-1:0]    top_of_return_stack;
  assign o_instr = imem[i_pc];
  assign o_rdata = rf[i_raddr];
  always @(posedge i_ref_clk) begin
    if (i_we) rf[i_waddr] <= i_wdata;
    if (i_push) top_of_return_stack <= i_push_addr;
  end
endmodule : bbx_mem_model

/* File: test/bit_and_branch_instruction_exec_test.sv */
`timescale 1ns/1ns
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("Error %s expected %0h seen %0h", n, e, a); end end
module bit_and_branch_instruction_exec_test;
  import bbx_pkg::*;
  logic               i_ref_clk = 1'b0, i_nrst = 1'b0, i_cyc_en = 1'b1;
  logic [PC_W-1:0]    o_pc, o_push_addr;
  logic [INSTR_W-1:0] i_instr;
  logic [RADDR_W-1:0] o_rf_raddr, o_rf_waddr;
  logic [DATA_W-1:0]  i_rf_rdata, o_rf_wdata, i_wreg = 8'h00;
  logic [LATCH_W-1:0] i_upper_pc_latch = 7'h00;
  logic               o_rf_we, o_push, o_retire, o_foreign, o_nop;
  logic [CNT_W-1:0]   o_cycles;
  int                 errors = 0, num_checks = 0;
  bbx_exec u_dut (.*);
  bbx_mem_model u_mem (.i_ref_clk, .i_we(o_rf_we), .i_push(o_push), .i_pc(o_pc),
    .i_push_addr(o_push_addr), .i_raddr(o_rf_raddr), .i_waddr(o_rf_waddr),
    .i_wdata(o_rf_wdata), .o_instr(i_instr), .o_rdata(i_rf_rdata));
  initial forever #10 i_ref_clk = ~i_ref_clk;
  // Each test restarts from address zero, so expectations need no history
  task automatic rst(input logic [INSTR_W-1:0] op, input logic [RADDR_W-1:0] fa,
                     input logic [DATA_W-1:0] fv);
    // One more cycle first, so a discard cycle of the last test completes
    @(negedge i_ref_clk);
    i_nrst = 1'b0;
    u_mem.imem[0] = op;
    repeat (10) @(negedge i_ref_clk);
    // Preload only now, after any posted write of the last test has landed
    u_mem.rf[fa] = fv;
    i_nrst = 1'b1;
    @(negedge i_ref_clk);
  endtask : rst
  task automatic t_bits();
    for (int i = 0; i < 2; i++) begin
      rst({BITOP_GRP, i ? SEL_SET : SEL_CLR, i ? 3'h6 : 3'h0, 7'h7F}, 7'h7F, 8'hA5);
      `CHK("we", 1'b1, o_rf_we);
      `CHK("retire", 1'b1, o_retire);
      `CHK("waddr", 7'h7F, o_rf_waddr);
      `CHK("wdata", i ? 8'hE5 : 8'hA4, o_rf_wdata);
    end
    $display("t_bits done");
  endtask : t_bits
  task automatic t_skip();
    for (int i = 0; i < 4; i++) begin
      rst({BITOP_GRP, i[1] ? SEL_TSTSET : SEL_TSTCLR, i[0] ? 3'h4 : 3'h3, 7'h09}, 7'h09, 8'h10);
      `CHK("pc", i[1] == i[0] ? 15'h0002 : 15'h0001, o_pc);
      @(negedge i_ref_clk);
      `CHK("nop", i[1] == i[0], o_nop);
    end
    $display("t_skip done");
  endtask : t_skip
  task automatic t_branch();
    logic [INSTR_W-1:0] ops [3] = '{{BRA_GRP, 9'h100}, {BRA_GRP, 9'h0FF}, BRW_CODE};
    logic [PC_W-1:0]    exps [3] = '{15'h7F01, 15'h0100, 15'h0100};
    i_wreg = 8'hFF;
    for (int i = 0; i < 3; i++) begin
      rst(ops[i], 7'h00, 8'h00);
      `CHK("pc", exps[i], o_pc);
      @(negedge i_ref_clk);
      `CHK("nop", 1'b1, o_nop);
      `CHK("cycles", 32'h0000_0002, o_cycles);
    end
    $display("t_branch done");
  endtask : t_branch
  task automatic t_stall();
    rst({BRA_GRP, 9'h0FF}, 7'h00, 8'h00);
    i_cyc_en = 1'b0;
    @(negedge i_ref_clk);
    `CHK("stall pc", 15'h0100, o_pc);
    `CHK("stall nop", 1'b0, o_nop);
    `CHK("stall cycles", 32'h0000_0001, o_cycles);
    i_cyc_en = 1'b1;
    @(negedge i_ref_clk);
    `CHK("nop", 1'b1, o_nop);
    `CHK("cycles", 32'h0000_0002, o_cycles);
    $display("t_stall done");
  endtask : t_stall
  task automatic t_call();
    i_upper_pc_latch = 7'h5A;
    rst({CALL_GRP, 11'h7FF}, 7'h00, 8'h00);
    `CHK("pc", 15'h5FFF, o_pc);
    `CHK("push", 1'b1, o_push);
    `CHK("retaddr", 15'h0001, o_push_addr);
    @(negedge i_ref_clk);
    `CHK("nop", 1'b1, o_nop);
    `CHK("cycles", 32'h0000_0002, o_cycles);
    `CHK("tos", 15'h0001, u_mem.top_of_return_stack);
    @(negedge i_ref_clk);
    `CHK("foreign", 1'b1, o_foreign);
    `CHK("next pc", 15'h6000, o_pc);
    $display("t_call done");
  endtask : t_call
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
  initial begin
    t_bits();
    t_skip();
    t_branch();
    t_stall();
    t_call();
    wrap_up();
  end
endmodule : bit_and_branch_instruction_exec_test
